// File: logic/mbc_pkg.sv
// shared constants for the modbus command slave and master ends
package mbc_pkg;
  localparam logic [7:0] MBC_FC_RD_HOLD = 8'h03;
  localparam logic [7:0] MBC_FC_RD_INP = 8'h04;
  localparam logic [7:0] MBC_FC_WR_ONE = 8'h06;
  localparam logic [7:0] MBC_FC_DIAG = 8'h08;
  localparam logic [7:0] MBC_FC_WR_MULT = 8'h10;
  localparam logic [7:0] MBC_FC_RW_MULT = 8'h17;
  localparam logic [7:0] MBC_EXC_FLAG = 8'h80;
  localparam logic [7:0] MBC_EXC_ILL_FUNC = 8'h01;
  localparam logic [7:0] MBC_EXC_ILL_VALUE = 8'h03;
  localparam logic [15:0] MBC_SUB_ECHO = 16'h0000;
  localparam logic [15:0] MBC_SUB_DIAGREG = 16'h0002;
  localparam logic [7:0] MBC_MAX_RD = 8'h7D;
  localparam logic [7:0] MBC_MAX_WR = 8'h78;
  localparam logic [7:0] MBC_MAX_RW = 8'h76;
  localparam logic [7:0] MBC_CNT_ONE = 8'h01;
  localparam logic [7:0] MBC_CNT_ZERO = 8'h00;
  localparam logic [15:0] MBC_DIAG_RESET = 16'h0000;
  localparam int MBC_REGS = 256;
  localparam int MBC_AW = 8;
  // byte order selectors
  localparam logic [1:0] MBC_BO_1032 = 2'h0;
  localparam logic [1:0] MBC_BO_0123 = 2'h1;
  localparam logic [1:0] MBC_BO_2301 = 2'h2;
  localparam logic [1:0] MBC_BO_3210 = 2'h3;
  // response delay
  localparam int MBC_CLK_HZ = 50000000;
  localparam int MBC_RESP_MS = 3;
  localparam int MBC_RESP_CYC = MBC_CLK_HZ / 1000 * MBC_RESP_MS;
  localparam logic [7:0] MBC_LAST_WORD = 8'hFF;
endpackage

// File: logic/mbc_link_if.sv
// word-level link between the modbus master end and the slave end
`timescale 1ns/100ps
interface mbc_link_if;
  import mbc_pkg::*;
  logic req_valid;
  logic [7:0] req_func;
  logic req_bcast;
  logic [15:0] req_addr;
  logic [7:0] req_cnt;
  logic [15:0] req_waddr;
  logic [7:0] req_wcnt;
  logic req_wvalid;
  logic [15:0] req_wdata;
  logic req_wlast;
  logic req_ready;
  logic rsp_valid;
  logic [7:0] rsp_func;
  logic [7:0] rsp_bytes;
  logic [15:0] rsp_data;
  logic rsp_last;
  modport slave (
    input req_valid, req_func, req_bcast, req_addr, req_cnt, req_waddr, req_wcnt,
    input req_wvalid, req_wdata, req_wlast,
    output req_ready, rsp_valid, rsp_func, rsp_bytes, rsp_data, rsp_last
  );
  modport master (
    output req_valid, req_func, req_bcast, req_addr, req_cnt, req_waddr, req_wcnt,
    output req_wvalid, req_wdata, req_wlast,
    input req_ready, rsp_valid, rsp_func, rsp_bytes, rsp_data, rsp_last
  );
endinterface

// File: logic/mbc_slave.sv
// modbus register command slave: decode, write, read back, answer
`timescale 1ns/100ps
module mbc_slave
  import mbc_pkg::*;
#(
  parameter int RESP_CYC = MBC_RESP_CYC
)
(
  input wire logic clk,
  input wire logic resetn,
  mbc_link_if.slave lnk,
  input wire logic [1:0] byte_order,
  input wire logic [MBC_AW-1:0] par_addr,
  input wire logic par_wr,
  input wire logic [31:0] par_wdata,
  input wire logic par_is_float,
  output logic [15:0] diag_reg_r
);
  typedef enum logic [5:0] {
    MBC_S_IDLE = 6'b000001,
    MBC_S_WRITE = 6'b000010,
    MBC_S_WAIT = 6'b000100,
    MBC_S_HEAD = 6'b001000,
    MBC_S_READ = 6'b010000,
    MBC_S_DONE = 6'b100000
  } mbc_state_t;

  logic [15:0] mem [MBC_REGS];
  mbc_state_t st_r, st_nxt;
  logic [7:0] func_r, func_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic [MBC_AW-1:0] ptr_r, ptr_nxt;
  logic [MBC_AW-1:0] rptr_r, rptr_nxt;
  logic [7:0] left_r, left_nxt;
  logic [7:0] exc_r, exc_nxt;
  logic [15:0] echo_r, echo_nxt;
  logic [31:0] wait_r, wait_nxt;
  logic ready_r, ready_nxt;
  logic bc_r, bc_nxt;
  logic rv_r, rv_nxt;
  logic [7:0] rf_r, rf_nxt;
  logic [7:0] rb_r, rb_nxt;
  logic [15:0] rd_r, rd_nxt;
  logic rl_r, rl_nxt;
  logic [15:0] diag_nxt;
  logic mem_we;
  logic [MBC_AW-1:0] mem_wa;
  logic [15:0] mem_wd;
  logic [15:0] par_hi, par_lo;
  logic acts;

  assign lnk.req_ready = ready_r;
  assign lnk.rsp_valid = rv_r;
  assign lnk.rsp_func = rf_r;
  assign lnk.rsp_bytes = rb_r;
  assign lnk.rsp_data = rd_r;
  assign lnk.rsp_last = rl_r;

  // parameter packing into link words; float splits into two registers
  always_comb begin
    par_hi = par_wdata[31:16];
    par_lo = par_wdata[15:0];
    case (byte_order)
      MBC_BO_0123: begin
        par_hi = {par_wdata[7:0], par_wdata[15:8]};
        par_lo = {par_wdata[23:16], par_wdata[31:24]};
      end
      MBC_BO_2301: begin
        par_hi = {par_wdata[23:16], par_wdata[31:24]};
        par_lo = {par_wdata[7:0], par_wdata[15:8]};
      end
      MBC_BO_3210: begin
        par_hi = par_wdata[31:16];
        par_lo = par_wdata[15:0];
      end
      default: begin
        // factory order 1-0-3-2 puts the low word first
        par_hi = par_wdata[15:0];
        par_lo = par_wdata[31:16];
      end
    endcase
    if (!par_is_float && (byte_order == MBC_BO_0123 || byte_order == MBC_BO_2301)) begin
      par_lo = {par_wdata[7:0], par_wdata[15:8]};
    end else if (!par_is_float) begin
      par_lo = par_wdata[15:0];
    end
  end

  // broadcast is only legal for write codes
  assign acts = !lnk.req_bcast || lnk.req_func == MBC_FC_WR_ONE || lnk.req_func == MBC_FC_WR_MULT
                || lnk.req_func == MBC_FC_RW_MULT;

  always_comb begin
    st_nxt = st_r;
    func_nxt = func_r;
    cnt_nxt = cnt_r;
    ptr_nxt = ptr_r;
    rptr_nxt = rptr_r;
    left_nxt = left_r;
    exc_nxt = exc_r;
    echo_nxt = echo_r;
    wait_nxt = wait_r;
    ready_nxt = ready_r;
    bc_nxt = bc_r;
    rv_nxt = 1'b0;
    rf_nxt = rf_r;
    rb_nxt = rb_r;
    rd_nxt = rd_r;
    rl_nxt = 1'b0;
    diag_nxt = diag_reg_r;
    mem_we = 1'b0;
    mem_wa = ptr_r;
    mem_wd = lnk.req_wdata;
    case (st_r)
      MBC_S_IDLE: begin
        ready_nxt = 1'b1;
        if (lnk.req_valid && ready_r) begin
          ready_nxt = 1'b0;
          func_nxt = lnk.req_func;
          cnt_nxt = lnk.req_cnt;
          rptr_nxt = lnk.req_addr[MBC_AW-1:0];
          ptr_nxt = lnk.req_waddr[MBC_AW-1:0];
          left_nxt = lnk.req_wcnt;
          echo_nxt = lnk.req_waddr;
          exc_nxt = MBC_CNT_ZERO;
          bc_nxt = lnk.req_bcast;
          wait_nxt = 32'(RESP_CYC);
          st_nxt = MBC_S_WAIT;
          case (lnk.req_func)
            MBC_FC_RD_HOLD, MBC_FC_RD_INP: begin
              func_nxt = MBC_FC_RD_HOLD;
              if (lnk.req_cnt == MBC_CNT_ZERO || lnk.req_cnt > MBC_MAX_RD) exc_nxt = MBC_EXC_ILL_VALUE;
            end
            MBC_FC_WR_ONE: begin
              ptr_nxt = lnk.req_addr[MBC_AW-1:0];
              left_nxt = MBC_CNT_ONE;
              st_nxt = MBC_S_WRITE;
            end
            MBC_FC_DIAG: begin
              if (lnk.req_addr != MBC_SUB_ECHO && lnk.req_addr != MBC_SUB_DIAGREG) exc_nxt = MBC_EXC_ILL_VALUE;
            end
            MBC_FC_WR_MULT: begin
              ptr_nxt = lnk.req_addr[MBC_AW-1:0];
              left_nxt = lnk.req_cnt;
              if (lnk.req_cnt == MBC_CNT_ZERO || lnk.req_cnt > MBC_MAX_WR) exc_nxt = MBC_EXC_ILL_VALUE;
              else st_nxt = MBC_S_WRITE;
            end
            MBC_FC_RW_MULT: begin
              if (lnk.req_cnt == MBC_CNT_ZERO || lnk.req_cnt > MBC_MAX_RW || lnk.req_wcnt == MBC_CNT_ZERO
                  || lnk.req_wcnt > MBC_MAX_RW) exc_nxt = MBC_EXC_ILL_VALUE;
              else st_nxt = MBC_S_WRITE;
            end
            default: exc_nxt = MBC_EXC_ILL_FUNC;
          endcase
          if (!acts) begin
            st_nxt = MBC_S_IDLE;
            ready_nxt = 1'b1;
          end
          if (lnk.req_bcast) diag_nxt = diag_reg_r + 16'h0001;
        end
      end
      MBC_S_WRITE: begin
        // write words are taken whatever the timer; the delay counts from here
        if (lnk.req_wvalid) begin
          mem_we = 1'b1;
          ptr_nxt = ptr_r + 8'h01;
          left_nxt = left_r - 8'h01;
          if (func_r == MBC_FC_WR_ONE) echo_nxt = lnk.req_wdata;
          if (left_r == MBC_CNT_ONE || lnk.req_wlast) st_nxt = MBC_S_WAIT;
        end
        if (wait_r != 32'h0000_0000) wait_nxt = wait_r - 32'h0000_0001;
      end
      MBC_S_WAIT: begin
        if (wait_r != 32'h0000_0000) wait_nxt = wait_r - 32'h0000_0001;
        else if (bc_r) begin
          // a broadcast write gets no answer at all
          ready_nxt = 1'b1;
          st_nxt = MBC_S_IDLE;
        end else st_nxt = MBC_S_HEAD;
      end
      MBC_S_HEAD: begin
        rv_nxt = 1'b1;
        rl_nxt = 1'b1;
        rd_nxt = echo_r;
        rb_nxt = MBC_CNT_ZERO;
        rf_nxt = func_r;
        st_nxt = MBC_S_DONE;
        if (exc_r != MBC_CNT_ZERO) begin
          rf_nxt = func_r | MBC_EXC_FLAG;
          rd_nxt = {8'h00, exc_r};
        end else if (func_r == MBC_FC_DIAG && rptr_r == MBC_SUB_DIAGREG[MBC_AW-1:0]) begin
          rd_nxt = diag_reg_r;
        end else if (func_r == MBC_FC_RD_HOLD || func_r == MBC_FC_RW_MULT) begin
          rb_nxt = 8'({cnt_r, 1'b0});
          rl_nxt = 1'b0;
          rv_nxt = 1'b0;
          left_nxt = cnt_r;
          st_nxt = MBC_S_READ;
        end
      end
      MBC_S_READ: begin
        rv_nxt = 1'b1;
        rd_nxt = mem[rptr_r];
        rptr_nxt = rptr_r + 8'h01;
        left_nxt = left_r - 8'h01;
        if (left_r == MBC_CNT_ONE) begin
          rl_nxt = 1'b1;
          st_nxt = MBC_S_DONE;
        end
      end
      default: begin
        ready_nxt = 1'b1;
        st_nxt = MBC_S_IDLE;
      end
    endcase
    if (par_wr && !mem_we) begin
      mem_we = 1'b1;
      mem_wa = par_addr;
      mem_wd = par_is_float ? par_hi : par_lo;
    end
  end

  always_ff @(posedge clk) begin
    if (mem_we) mem[mem_wa] <= mem_wd;
    if (par_wr && par_is_float && mem_wa != par_addr + 8'h01) mem[par_addr + 8'h01] <= par_lo;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= MBC_S_IDLE;
      func_r <= MBC_CNT_ZERO;
      cnt_r <= MBC_CNT_ZERO;
      ptr_r <= '0;
      rptr_r <= '0;
      left_r <= MBC_CNT_ZERO;
      exc_r <= MBC_CNT_ZERO;
      echo_r <= MBC_DIAG_RESET;
      wait_r <= 32'h0000_0000;
      ready_r <= 1'b0;
      bc_r <= 1'b0;
      rv_r <= 1'b0;
      rf_r <= MBC_CNT_ZERO;
      rb_r <= MBC_CNT_ZERO;
      rd_r <= MBC_DIAG_RESET;
      rl_r <= 1'b0;
      diag_reg_r <= MBC_DIAG_RESET;
    end else begin
      st_r <= st_nxt;
      func_r <= func_nxt;
      cnt_r <= cnt_nxt;
      ptr_r <= ptr_nxt;
      rptr_r <= rptr_nxt;
      left_r <= left_nxt;
      exc_r <= exc_nxt;
      echo_r <= echo_nxt;
      wait_r <= wait_nxt;
      ready_r <= ready_nxt;
      bc_r <= bc_nxt;
      rv_r <= rv_nxt;
      rf_r <= rf_nxt;
      rb_r <= rb_nxt;
      rd_r <= rd_nxt;
      rl_r <= rl_nxt;
      diag_reg_r <= diag_nxt;
    end
  end
endmodule

// File: logic/mbc_master.sv
// modbus master end: issues one request and collects the answer words
`timescale 1ns/100ps
module mbc_master
  import mbc_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  mbc_link_if.master lnk,
  input wire logic cmd_start,
  input wire logic [7:0] cmd_func,
  input wire logic cmd_bcast,
  input wire logic [15:0] cmd_addr,
  input wire logic [7:0] cmd_cnt,
  input wire logic [15:0] cmd_waddr,
  input wire logic [7:0] cmd_wcnt,
  input wire logic [15:0] cmd_wdata,
  output logic busy_r,
  output logic rd_valid_r,
  output logic [15:0] rd_data_r,
  output logic done_r,
  output logic [7:0] done_func_r
);
  typedef enum logic [3:0] {
    MBC_M_IDLE = 4'b0001,
    MBC_M_REQ = 4'b0010,
    MBC_M_DATA = 4'b0100,
    MBC_M_RSP = 4'b1000
  } mbc_mstate_t;

  mbc_mstate_t st_r, st_nxt;
  logic rv_r, rv_nxt;
  logic [7:0] fn_r, fn_nxt;
  logic bc_r, bc_nxt;
  logic [15:0] ad_r, ad_nxt;
  logic [7:0] cn_r, cn_nxt;
  logic [15:0] wa_r, wa_nxt;
  logic [7:0] wc_r, wc_nxt;
  logic wv_r, wv_nxt;
  logic [15:0] wd_r, wd_nxt;
  logic wl_r, wl_nxt;
  logic busy_nxt, rdv_nxt, done_nxt;
  logic [15:0] rdd_nxt;
  logic [7:0] dfn_nxt;
  logic is_write;
  logic cnt_ok;

  assign lnk.req_valid = rv_r;
  assign lnk.req_func = fn_r;
  assign lnk.req_bcast = bc_r;
  assign lnk.req_addr = ad_r;
  assign lnk.req_cnt = cn_r;
  assign lnk.req_waddr = wa_r;
  assign lnk.req_wcnt = wc_r;
  assign lnk.req_wvalid = wv_r;
  assign lnk.req_wdata = wd_r;
  assign lnk.req_wlast = wl_r;

  assign is_write = fn_r == MBC_FC_WR_ONE || fn_r == MBC_FC_WR_MULT || fn_r == MBC_FC_RW_MULT;

  // master-side limits: a count above the maximum is never sent, though a zero count still goes out
  always_comb begin
    case (cmd_func)
      MBC_FC_RD_HOLD, MBC_FC_RD_INP: cnt_ok = cmd_cnt <= MBC_MAX_RD && !cmd_bcast;
      MBC_FC_WR_MULT: cnt_ok = cmd_cnt <= MBC_MAX_WR;
      MBC_FC_RW_MULT: cnt_ok = cmd_cnt <= MBC_MAX_RW && cmd_wcnt <= MBC_MAX_RW;
      MBC_FC_WR_ONE: cnt_ok = 1'b1;
      default: cnt_ok = !cmd_bcast;
    endcase
  end

  always_comb begin
    st_nxt = st_r;
    rv_nxt = rv_r;
    fn_nxt = fn_r;
    bc_nxt = bc_r;
    ad_nxt = ad_r;
    cn_nxt = cn_r;
    wa_nxt = wa_r;
    wc_nxt = wc_r;
    wv_nxt = 1'b0;
    wd_nxt = wd_r;
    wl_nxt = 1'b0;
    busy_nxt = busy_r;
    rdv_nxt = 1'b0;
    rdd_nxt = rd_data_r;
    done_nxt = 1'b0;
    dfn_nxt = done_func_r;
    case (st_r)
      MBC_M_IDLE: begin
        busy_nxt = 1'b0;
        if (cmd_start && cnt_ok) begin
          busy_nxt = 1'b1;
          rv_nxt = 1'b1;
          fn_nxt = cmd_func;
          bc_nxt = cmd_bcast;
          ad_nxt = cmd_addr;
          cn_nxt = cmd_cnt;
          wa_nxt = cmd_waddr;
          // code 16 streams its register count, code 23 its write count
          wc_nxt = (cmd_func == MBC_FC_WR_MULT) ? cmd_cnt : cmd_wcnt;
          st_nxt = MBC_M_REQ;
        end
      end
      MBC_M_REQ: begin
        if (lnk.req_ready) begin
          rv_nxt = 1'b0;
          if (bc_r) st_nxt = is_write ? MBC_M_DATA : MBC_M_IDLE;
          else st_nxt = is_write ? MBC_M_DATA : MBC_M_RSP;
        end
      end
      MBC_M_DATA: begin
        // one word per cycle, streamed from the user data port
        wv_nxt = 1'b1;
        wd_nxt = cmd_wdata;
        // a zero count still ends after one word instead of wrapping
        if (wc_r <= MBC_CNT_ONE || fn_r == MBC_FC_WR_ONE) begin
          wl_nxt = 1'b1;
          st_nxt = bc_r ? MBC_M_IDLE : MBC_M_RSP;
        end
        wc_nxt = wc_r - 8'h01;
      end
      default: begin
        if (lnk.rsp_valid) begin
          rdv_nxt = 1'b1;
          rdd_nxt = lnk.rsp_data;
          if (lnk.rsp_last) begin
            done_nxt = 1'b1;
            dfn_nxt = lnk.rsp_func;
            st_nxt = MBC_M_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= MBC_M_IDLE;
      rv_r <= 1'b0;
      fn_r <= MBC_CNT_ZERO;
      bc_r <= 1'b0;
      ad_r <= 16'h0000;
      cn_r <= MBC_CNT_ZERO;
      wa_r <= 16'h0000;
      wc_r <= MBC_CNT_ZERO;
      wv_r <= 1'b0;
      wd_r <= 16'h0000;
      wl_r <= 1'b0;
      busy_r <= 1'b0;
      rd_valid_r <= 1'b0;
      rd_data_r <= 16'h0000;
      done_r <= 1'b0;
      done_func_r <= MBC_CNT_ZERO;
    end else begin
      st_r <= st_nxt;
      rv_r <= rv_nxt;
      fn_r <= fn_nxt;
      bc_r <= bc_nxt;
      ad_r <= ad_nxt;
      cn_r <= cn_nxt;
      wa_r <= wa_nxt;
      wc_r <= wc_nxt;
      wv_r <= wv_nxt;
      wd_r <= wd_nxt;
      wl_r <= wl_nxt;
      busy_r <= busy_nxt;
      rd_valid_r <= rdv_nxt;
      rd_data_r <= rdd_nxt;
      done_r <= done_nxt;
      done_func_r <= dfn_nxt;
    end
  end
endmodule

// File: test/mbc_link_props.sv
// concurrent checks on the link between the master end and the slave end
`timescale 1ns/100ps
module mbc_link_props
  import mbc_pkg::*;
#(
  parameter int RESP_CYC = MBC_RESP_CYC
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic [7:0] req_func,
  input wire logic req_bcast,
  input wire logic [7:0] req_cnt,
  input wire logic [7:0] req_wcnt,
  input wire logic req_wvalid,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_func,
  input wire logic [7:0] rsp_bytes,
  input wire logic [15:0] rsp_data,
  input wire logic rsp_last
);
  // slack for write words that stream while the answer delay already runs
  localparam int RESP_LO = RESP_CYC - 256;
  // upper end scales the nominal delay by five thirds
  localparam int RESP_HI = RESP_CYC / 3 * 5;
  logic take, sup, rd_f, first_r, silent_r;
  logic [7:0] f_r, c_r, wc_r, nw_r, nr_r;
  logic [19:0] gap_r;
  assign take = req_valid && req_ready;
  assign sup = f_r inside {MBC_FC_RD_HOLD, MBC_FC_RD_INP, MBC_FC_WR_ONE, MBC_FC_DIAG, MBC_FC_WR_MULT, MBC_FC_RW_MULT};
  assign rd_f = f_r inside {MBC_FC_RD_HOLD, MBC_FC_RD_INP, MBC_FC_RW_MULT};
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      f_r <= 8'h00;
      c_r <= 8'h00;
      wc_r <= 8'h00;
      nw_r <= 8'h00;
      nr_r <= 8'h00;
      gap_r <= 20'h0_0000;
      first_r <= 1'b0;
      silent_r <= 1'b0;
    end else begin
      if (take) begin
        f_r <= req_func;
        c_r <= req_cnt;
        wc_r <= req_wcnt;
        first_r <= 1'b1;
        // no broadcast is ever answered or refused, though broadcast writes are still carried out
        silent_r <= req_bcast;
        nw_r <= 8'h00;
        nr_r <= 8'h00;
      end else begin
        if (req_wvalid) nw_r <= nw_r + 8'h01;
        if (rsp_valid) nr_r <= nr_r + 8'h01;
        if (rsp_valid) first_r <= 1'b0;
      end
      if (take || req_wvalid) gap_r <= 20'h0_0000;
      else if (gap_r != 20'hF_FFFF) gap_r <= gap_r + 20'h0_0001;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_rsp_delay_window: assert property (rsp_valid && first_r |-> gap_r >= RESP_LO && gap_r <= RESP_HI)
    else $error("answer outside the response window");
  a_bytes_double: assert property (rsp_valid && !rsp_func[7] && rd_f |-> rsp_bytes == {c_r[6:0], 1'b0})
    else $error("byte count is not twice the register count");
  a_rd_limit: assert property (rsp_valid && (f_r == MBC_FC_RD_HOLD || f_r == MBC_FC_RD_INP) && c_r != 8'h00
    |-> rsp_func[7] == (c_r > MBC_MAX_RD))
    else $error("read count limit misjudged");
  a_wr_limit: assert property (rsp_valid && f_r == MBC_FC_WR_MULT && c_r != 8'h00
    |-> rsp_func[7] == (c_r > MBC_MAX_WR))
    else $error("write count limit misjudged");
  a_rw_limit: assert property (rsp_valid && f_r == MBC_FC_RW_MULT && c_r != 8'h00 && wc_r != 8'h00
    |-> rsp_func[7] == (c_r > MBC_MAX_RW || wc_r > MBC_MAX_RW))
    else $error("combined count limit misjudged");
  a_func_echo: assert property (rsp_valid && !rsp_func[7]
    |-> rsp_func == ((f_r == MBC_FC_RD_INP) ? MBC_FC_RD_HOLD : f_r))
    else $error("answer code does not match request");
  a_bad_func: assert property (rsp_valid && !sup
    |-> rsp_func == (f_r | MBC_EXC_FLAG) && rsp_data[7:0] == MBC_EXC_ILL_FUNC)
    else $error("unknown code not refused");
  a_exc_single: assert property (rsp_valid && rsp_func[7] |-> rsp_last && first_r)
    else $error("exception answer is not one word");
  a_rw_order: assert property (rsp_valid && f_r == MBC_FC_RW_MULT && !rsp_func[7] |-> nw_r == wc_r)
    else $error("combined read answered before all writes");
  a_rd_count: assert property (rsp_valid && rsp_last && !rsp_func[7] && rd_f |-> nr_r + 8'h01 == c_r)
    else $error("read word count wrong");
  a_bcast_silent: assert property (silent_r |-> !rsp_valid)
    else $error("answer to a broadcast");
endmodule

// File: test/modbus_register_command_slave_bench.sv
// self-checking bench joining the master end and the slave end
`timescale 1ns/100ps
module modbus_register_command_slave_bench;
  import mbc_pkg::*;
  logic clk, resetn, cmd_start, cmd_bcast, par_wr, par_is_float, busy_r, rd_valid_r, done_r;
  logic [7:0] cmd_func, cmd_cnt, cmd_wcnt, par_addr, dfunc, a, done_func_r;
  logic [15:0] cmd_addr, cmd_waddr, cmd_wdata, rd_data_r, lastrsp, v, diag_reg_r;
  logic [1:0] byte_order;
  logic [31:0] par_wdata, p, e;
  logic [15:0] mem [256];
  logic [15:0] rdq [$];
  logic [15:0] wq [$];
  logic [15:0] subs [3] = '{16'h0000, 16'h0002, 16'h0005};
  logic [7:0] bf [4] = '{8'h05, MBC_FC_RD_HOLD, MBC_FC_WR_MULT, MBC_FC_RW_MULT};
  // zero counts for the three count-checked codes, since the master itself holds back counts above the limit
  logic [7:0] bc [4] = '{8'h01, 8'h00, 8'h00, 8'h00};
  logic [7:0] bx [4] = '{MBC_EXC_ILL_FUNC, MBC_EXC_ILL_VALUE, MBC_EXC_ILL_VALUE, MBC_EXC_ILL_VALUE};
  int error_cnt, comparisons, n;
  // shortened answer delay keeps the run brief
  localparam int RESP_BENCH = 600;
  mbc_link_if lnk();
  mbc_slave #(.RESP_CYC(RESP_BENCH)) mbc_slave_inst(.clk(clk), .resetn(resetn), .lnk(lnk),
    .byte_order(byte_order), .par_addr(par_addr),
    .par_wr(par_wr), .par_wdata(par_wdata), .par_is_float(par_is_float), .diag_reg_r(diag_reg_r));
  mbc_master mbc_master_inst(.clk(clk), .resetn(resetn), .lnk(lnk), .cmd_start(cmd_start), .cmd_func(cmd_func),
    .cmd_bcast(cmd_bcast), .cmd_addr(cmd_addr), .cmd_cnt(cmd_cnt), .cmd_waddr(cmd_waddr), .cmd_wcnt(cmd_wcnt),
    .cmd_wdata(cmd_wdata), .busy_r(busy_r), .rd_valid_r(rd_valid_r), .rd_data_r(rd_data_r), .done_r(done_r),
    .done_func_r(done_func_r));
  mbc_link_props #(.RESP_CYC(RESP_BENCH)) mbc_link_props_inst(.clk(clk), .resetn(resetn),
    .req_valid(lnk.req_valid),
    .req_ready(lnk.req_ready), .req_func(lnk.req_func), .req_bcast(lnk.req_bcast), .req_cnt(lnk.req_cnt),
    .req_wcnt(lnk.req_wcnt), .req_wvalid(lnk.req_wvalid), .rsp_valid(lnk.rsp_valid), .rsp_func(lnk.rsp_func),
    .rsp_bytes(lnk.rsp_bytes), .rsp_data(lnk.rsp_data), .rsp_last(lnk.rsp_last));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // fresh write word every cycle, the master picks what it streams
  always @(negedge clk) cmd_wdata <= 16'($urandom);
  always @(posedge clk) begin
    if (rd_valid_r === 1'b1) rdq.push_back(rd_data_r);
    if (done_r === 1'b1) dfunc = done_func_r;
    if (lnk.req_wvalid === 1'b1) wq.push_back(lnk.req_wdata);
    if (lnk.rsp_valid === 1'b1) lastrsp = lnk.rsp_data;
  end
  // link byte order of a float for each selector
  function automatic logic [31:0] ef(input logic [1:0] bo, input logic [31:0] d);
    case (bo)
      2'h0: ef = {d[15:0], d[31:16]};
      2'h1: ef = {d[7:0], d[15:8], d[23:16], d[31:24]};
      2'h2: ef = {d[23:16], d[31:24], d[7:0], d[15:8]};
      default: ef = d;
    endcase
  endfunction
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
    comparisons++;
    if (got !== ex) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic par(input logic [7:0] ad, input logic [31:0] d, input logic fl, input logic [1:0] bo);
    @(negedge clk);
    byte_order = bo;
    par_addr = ad;
    par_wdata = d;
    par_is_float = fl;
    par_wr = 1'b1;
    @(negedge clk);
    par_wr = 1'b0;
  endtask
  // one request; the slave's answer delay is shortened for the bench
  task automatic run(input logic [7:0] f, input logic b, input logic [15:0] ad, input logic [7:0] c,
                     input logic [15:0] wa, input logic [7:0] wc);
    int k;
    @(negedge clk);
    rdq.delete();
    wq.delete();
    dfunc = 8'h00;
    cmd_func = f;
    cmd_bcast = b;
    cmd_addr = ad;
    cmd_cnt = c;
    cmd_waddr = wa;
    cmd_wcnt = wc;
    cmd_start = 1'b1;
    @(negedge clk);
    cmd_start = 1'b0;
    k = 0;
    while (k < 4 || busy_r !== 1'b0) begin
      @(negedge clk);
      k++;
      if (k > 3000) begin
        error_cnt++;
        finish_test();
      end
    end
    repeat (3) @(negedge clk);
    $display("test func %h done", f);
  endtask
  task automatic chk_rd(input logic [7:0] ad, input int cn);
    chk("rd_count", 16'(cn), 16'(rdq.size()));
    for (int i = 0; i < cn; i++) chk("rd_data", mem[ad + i], rdq[i]);
  endtask
  task automatic wr_mem(input logic [7:0] ad);
    foreach (wq[i]) mem[ad + i] = wq[i];
  endtask
  initial begin
    resetn = 1'b0;
    {cmd_start, cmd_bcast, par_wr, par_is_float, cmd_func, cmd_cnt, cmd_wcnt, par_addr} = '0;
    {cmd_addr, cmd_waddr, byte_order, par_wdata} = '0;
    error_cnt = 0;
    comparisons = 0;
    void'($urandom(25));
    repeat (4) @(posedge clk);
    @(negedge clk) resetn = 1'b1;
    repeat (4) @(negedge clk);
    for (int i = 0; i < 4; i++) begin
      p = $urandom;
      par(8'h40 + 8'(2 * i), p, 1'b1, 2'(i));
      e = ef(2'(i), p);
      mem[8'h40 + 2 * i] = e[31:16];
      mem[8'h41 + 2 * i] = e[15:0];
    end
    p = $urandom;
    par(8'h48, p, 1'b0, MBC_BO_1032);
    mem[8'h48] = p[15:0];
    par(8'h49, p, 1'b0, MBC_BO_0123);
    mem[8'h49] = {p[7:0], p[15:8]};
    run(MBC_FC_RD_HOLD, 1'b0, 16'h0040, 8'h0A, 16'h0000, 8'h00);
    chk_rd(8'h40, 10);
    a = 8'h10 + 8'($urandom % 32);
    n = 4 + $urandom % 5;
    run(MBC_FC_WR_MULT, 1'b0, {8'h00, a}, 8'(n), 16'h0000, 8'h00);
    chk("wr_words", 16'(n), 16'(wq.size()));
    chk("wr_func", {8'h00, MBC_FC_WR_MULT}, {8'h00, dfunc});
    wr_mem(a);
    run(MBC_FC_RD_HOLD, 1'b0, {8'h00, a}, 8'(n), 16'h0000, 8'h00);
    chk_rd(a, n);
    run(MBC_FC_RD_INP, 1'b0, {8'h00, a}, 8'(n), 16'h0000, 8'h00);
    chk_rd(a, n);
    chk("inp_func", {8'h00, MBC_FC_RD_HOLD}, {8'h00, dfunc});
    v = 16'($urandom);
    run(MBC_FC_WR_ONE, 1'b1, {8'h00, a + 8'h01}, MBC_CNT_ONE, v, 8'h00);
    mem[a + 1] = (wq.size() > 0) ? wq[0] : v;
    chk("bcast_cnt", 16'h0001, diag_reg_r);
    run(MBC_FC_RW_MULT, 1'b0, {8'h00, a}, 8'(n), {8'h00, a + 8'h02}, 8'h02);
    wr_mem(a + 8'h02);
    chk_rd(a, n);
    for (int i = 0; i < 3; i++) begin
      v = 16'($urandom);
      run(MBC_FC_DIAG, 1'b0, subs[i], MBC_CNT_ONE, v, 8'h00);
      case (i)
        0: chk("diag_echo", v, rdq[$]);
        1: chk("diag_reg", 16'h0001, rdq[$]);
        default: chk("diag_sub", {8'h00, MBC_FC_DIAG | MBC_EXC_FLAG}, {8'h00, dfunc});
      endcase
    end
    for (int i = 0; i < 4; i++) begin
      run(bf[i], 1'b0, {8'h00, a}, bc[i], {8'h00, a}, MBC_CNT_ONE);
      chk("exc_func", {8'h00, bf[i] | MBC_EXC_FLAG}, {8'h00, dfunc});
      chk("exc_code", {8'h00, bx[i]}, {8'h00, lastrsp[7:0]});
    end
    run(MBC_FC_RD_HOLD, 1'b1, {8'h00, a}, 8'h02, 16'h0000, 8'h00);
    chk("bcast_read", 16'h0000, 16'(rdq.size()));
    chk("bcast_drop", 16'h0001, diag_reg_r);
    // the master holds back a count above the limit
    run(MBC_FC_RD_HOLD, 1'b0, {8'h00, a}, 8'h7E, 16'h0000, 8'h00);
    chk("rd_limit", 16'h0000, {8'h00, dfunc});
    finish_test();
  end
  // fifteen requests of at most about 650 cycles each, with margin
  initial begin
    repeat (30000) @(posedge clk);
    error_cnt++;
    finish_test();
  end
endmodule
